//--- hw/nvw_pkg.sv
// package: register map, field layout, reset values and carrier types for the data memory write control
package nvw_pkg;

  // ==========================================================================
  // geometry
  localparam int NVW_ADDR_BITS   = 11;
  localparam int NVW_OFFSET_BITS = 4;
  localparam int NVW_PAGE_BITS   = NVW_ADDR_BITS - NVW_OFFSET_BITS;
  localparam int NVW_PAGE_BYTES  = 16;
  localparam int NVW_HIGH_BITS   = NVW_ADDR_BITS - 8;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] NVW_OFS_ADDR_HIGH = 8'h00;
  localparam logic [7:0] NVW_OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] NVW_OFS_DATA      = 8'h08;
  localparam logic [7:0] NVW_OFS_CONTROL   = 8'h0C;
  localparam logic [7:0] NVW_OFS_IRQ       = 8'h10;
  localparam logic [7:0] NVW_OFS_PTR1_HIGH = 8'h14;
  localparam logic [7:0] NVW_OFS_PTR2_HIGH = 8'h18;

  // ==========================================================================
  // control register fields
  localparam int NVW_BIT_MODE  = 4;
  localparam int NVW_BIT_WRITE_ENABLE_FLAG  = 3;
  localparam int NVW_BIT_WR    = 2;

  // interrupt register fields
  localparam int NVW_BIT_GIE     = 0;
  localparam int NVW_BIT_DONE_EN = 1;
  localparam int NVW_BIT_MF_EN   = 2;
  localparam int NVW_BIT_DONE_FL = 4;
  localparam int NVW_BIT_MF_FL   = 5;

  // ==========================================================================
  // reset values and constants
  localparam logic [7:0]                 NVW_RST_BYTE     = 8'h00;
  localparam logic [7:0]                 NVW_CTRL_SECTOR  = 8'h01;
  localparam logic [NVW_OFFSET_BITS-1:0] NVW_OFFSET_LAST  = 4'hF;
  localparam logic [NVW_OFFSET_BITS-1:0] NVW_OFFSET_STEP  = 4'h1;
  localparam logic [NVW_PAGE_BYTES-1:0]  NVW_RST_MASK     = 16'h0000;
  localparam int                         NVW_SYNC_STAGES  = 3;

  // ==========================================================================
  // write cycle sequencer
  typedef enum logic [1:0] {
    NVW_IDLE    = 2'b00,
    NVW_BUSY    = 2'b01,
    NVW_RELEASE = 2'b11
  } nvw_state_type;

  // request towards the memory array and its timer
  typedef struct packed {
    logic                           req;
    logic                           page_mode;
    logic                           erase_first;
    logic [NVW_ADDR_BITS-1:0]       addr;
    logic [7:0]                     byte_data;
    logic [NVW_PAGE_BYTES-1:0]      page_mask;
    logic [NVW_PAGE_BYTES*8-1:0]    page_data;
  } nvw_mem_req_type;

endpackage

//--- hw/nvw_sync.sv
// three-stage synchroniser whose output follows once the last two stages agree
`timescale 1ns/1ps
module nvw_sync
  import nvw_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // stages
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("nvw_sync: WIDTH must be at least 1");
  end

  // stage1 feeds stage2 only; agreement filters a late-settling stage2
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i])
          sync_out[i] <= stage3[i];
      end
    end
  end

endmodule

//--- hw/nvw_write_ctrl.sv
// data memory write control: registers, page buffer, launch sequence, completion and interrupt flags
//
// What this block does
// - byte mode writes data register at address
// - launch needs enable then start, consecutively
// - start ignored unless enable already set
// - async timer ends cycle; poll or interrupt
// - hardware clears start flag at end
// - hardware clears enable flag at end
// - byte write erases target byte first
// - page mode writes up to sixteen bytes
// - buffer cleared at reset, enable fall
// - upper seven bits page, lower four offset
// - page data write loads buffer, bumps offset
// - offset stops at 0FH, later writes dropped
// - enable flag cleared at reset
// - pointer high bytes reset, gate control access
// - cycle end sets done and shared flags
// - vector request needs all enables, stack free
// - service clears shared flag; software clears done
// - mode bit4, enable bit3, start bit2
`timescale 1ns/1ps
module nvw_write_ctrl
  import nvw_pkg::*;
#(
  parameter int ADDR_BITS = NVW_ADDR_BITS
)(
  input  wire logic            CLOCK,
  input  wire logic            RESET,
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [7:0]      PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  output nvw_mem_req_type      MEM_REQUEST,
  input  wire logic            MEM_DONE,
  input  wire logic            STACK_FULL,
  input  wire logic            IRQ_SERVICED,
  output logic                 IRQ_REQUEST
);

  // ==========================================================================
  // elaboration check
  // other widths would need a new page and offset split
  if (ADDR_BITS != NVW_ADDR_BITS)
  begin : g_bad_addr_bits
    $error("nvw_write_ctrl: ADDR_BITS must match the page geometry");
  end

  // ==========================================================================
  // state
  logic [NVW_HIGH_BITS-1:0]   nv_addr_high;
  logic [7:0]                 nv_addr_low;
  logic [7:0]                 nv_data_reg;
  logic                       mode_page;
  logic                       write_enable_flag;
  logic                       write_start_flag;
  logic                       write_enable_prev;
  logic                       launch_armed;
  logic                       offset_full;
  logic                       global_irq_enable;
  logic                       nv_done_irq_enable;
  logic                       mf_irq_enable;
  logic                       nv_done_irq_flag;
  logic                       mf_irq_flag;
  logic [7:0]                 pointer1_high_byte;
  logic [7:0]                 pointer2_high_byte;
  logic [7:0]                 page_buffer [NVW_PAGE_BYTES];
  logic [NVW_PAGE_BYTES-1:0]  page_mask;
  logic                       lat_page_mode;
  logic [ADDR_BITS-1:0]       lat_addr;
  logic [7:0]                 lat_byte;
  nvw_state_type              state;
  nvw_state_type              next_state;
  logic                       done_sync;

  // ==========================================================================
  // bus decode
  logic                       access_done;
  logic                       write_done;
  logic                       hit_addr_high;
  logic                       hit_addr_low;
  logic                       hit_data;
  logic                       hit_control;
  logic                       hit_irq;
  logic                       hit_ptr1;
  logic                       hit_ptr2;
  logic                       mapped;
  logic                       busy;
  logic                       sector_ok;
  logic                       ctrl_write;
  logic                       launch;
  logic                       cycle_end;
  logic                       buffer_clear;
  logic                       page_load;
  logic [NVW_OFFSET_BITS-1:0] offset;
  logic [31:0]                read_value;

  assign access_done   = PSEL && PENABLE;
  assign write_done    = access_done && PWRITE;
  assign hit_addr_high = (PADDR == NVW_OFS_ADDR_HIGH);
  assign hit_addr_low  = (PADDR == NVW_OFS_ADDR_LOW);
  assign hit_data      = (PADDR == NVW_OFS_DATA);
  assign hit_control   = (PADDR == NVW_OFS_CONTROL);
  assign hit_irq       = (PADDR == NVW_OFS_IRQ);
  assign hit_ptr1      = (PADDR == NVW_OFS_PTR1_HIGH);
  assign hit_ptr2      = (PADDR == NVW_OFS_PTR2_HIGH);
  assign mapped        = hit_addr_high || hit_addr_low || hit_data || hit_control
                         || hit_irq || hit_ptr1 || hit_ptr2;
  assign busy          = (state != NVW_IDLE);
  assign offset        = nv_addr_low[NVW_OFFSET_BITS-1:0];

  // control register only reachable with a pointer in its sector
  assign sector_ok  = (pointer1_high_byte == NVW_CTRL_SECTOR)
                      || (pointer2_high_byte == NVW_CTRL_SECTOR);
  assign ctrl_write = write_done && hit_control && sector_ok && !busy;

  // start bit honoured only right after the enable-setting write
  assign launch = ctrl_write && launch_armed
                  && PWDATA[NVW_BIT_WRITE_ENABLE_FLAG] && PWDATA[NVW_BIT_WR];

  // page load; at offset 0FH only the first write lands
  assign page_load = write_done && hit_data && !busy && mode_page && !offset_full;

  assign cycle_end    = (state == NVW_BUSY) && done_sync;
  assign buffer_clear = write_enable_prev && !write_enable_flag;

  // zero wait states; unmapped addresses answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = access_done && !mapped;

  // ==========================================================================
  // completion from the array timer
  nvw_sync #(
    .WIDTH    (1)
  ) u_done_sync (
    .clock    (CLOCK),
    .reset    (RESET),
    .async_in (MEM_DONE),
    .sync_out (done_sync)
  );

  // ==========================================================================
  // read data, captured in the setup cycle
  always_comb
  begin
    read_value = 32'h0000_0000;
    if (hit_addr_high)
      read_value[NVW_HIGH_BITS-1:0] = nv_addr_high;
    if (hit_addr_low)
      read_value[7:0] = nv_addr_low;
    if (hit_data)
      read_value[7:0] = nv_data_reg;
    if (hit_control && sector_ok)
    begin
      read_value[NVW_BIT_MODE] = mode_page;
      read_value[NVW_BIT_WRITE_ENABLE_FLAG] = write_enable_flag;
      read_value[NVW_BIT_WR]   = write_start_flag;
    end
    if (hit_irq)
    begin
      read_value[NVW_BIT_GIE]     = global_irq_enable;
      read_value[NVW_BIT_DONE_EN] = nv_done_irq_enable;
      read_value[NVW_BIT_MF_EN]   = mf_irq_enable;
      read_value[NVW_BIT_DONE_FL] = nv_done_irq_flag;
      read_value[NVW_BIT_MF_FL]   = mf_irq_flag;
    end
    if (hit_ptr1)
      read_value[7:0] = pointer1_high_byte;
    if (hit_ptr2)
      read_value[7:0] = pointer2_high_byte;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= read_value;
  end

  // ==========================================================================
  // address and data registers; frozen while a cycle runs
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      nv_addr_high <= '0;
      nv_addr_low  <= NVW_RST_BYTE;
      nv_data_reg  <= NVW_RST_BYTE;
      offset_full  <= 1'b0;
    end
    else if (write_done && !busy)
    begin
      if (hit_addr_high)
        nv_addr_high <= PWDATA[NVW_HIGH_BITS-1:0];
      if (hit_addr_low)
      begin
        nv_addr_low <= PWDATA[7:0];
        offset_full <= 1'b0;
      end
      if (hit_data && !mode_page)
        nv_data_reg <= PWDATA[7:0];
      if (page_load)
      begin
        nv_data_reg <= PWDATA[7:0];
        // page bits never move; offset saturates instead of wrapping
        if (offset == NVW_OFFSET_LAST)
          offset_full <= 1'b1;
        else
          nv_addr_low[NVW_OFFSET_BITS-1:0] <= offset + NVW_OFFSET_STEP;
      end
    end
  end

  // ==========================================================================
  // page buffer, one entry per byte
  generate
    for (genvar i = 0; i < NVW_PAGE_BYTES; i++)
    begin : g_entry
      always_ff @(posedge CLOCK)
      begin
        if (RESET || buffer_clear)
        begin
          page_buffer[i] <= NVW_RST_BYTE;
          page_mask[i]   <= 1'b0;
        end
        else if (page_load && (offset == NVW_OFFSET_BITS'(i)))
        begin
          page_buffer[i] <= PWDATA[7:0];
          page_mask[i]   <= 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // control register and launch sequence
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      mode_page         <= 1'b0;
      write_enable_flag <= 1'b0;
      write_start_flag  <= 1'b0;
      write_enable_prev <= 1'b0;
      launch_armed      <= 1'b0;
    end
    else
    begin
      write_enable_prev <= write_enable_flag;
      // any other transfer between the two writes breaks the sequence
      if (access_done)
        launch_armed <= ctrl_write && PWDATA[NVW_BIT_WRITE_ENABLE_FLAG] && !PWDATA[NVW_BIT_WR];
      if (cycle_end)
      begin
        write_start_flag  <= 1'b0;
        write_enable_flag <= 1'b0;
      end
      else if (ctrl_write)
      begin
        mode_page         <= PWDATA[NVW_BIT_MODE];
        write_enable_flag <= PWDATA[NVW_BIT_WRITE_ENABLE_FLAG];
        if (launch)
          write_start_flag <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // memory pointer high bytes
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      pointer1_high_byte <= NVW_RST_BYTE;
      pointer2_high_byte <= NVW_RST_BYTE;
    end
    else if (write_done)
    begin
      if (hit_ptr1)
        pointer1_high_byte <= PWDATA[7:0];
      if (hit_ptr2)
        pointer2_high_byte <= PWDATA[7:0];
    end
  end

  // ==========================================================================
  // write cycle sequencer: four-phase with the array timer
  always_comb
  begin
    next_state = state;
    unique case (state)
      NVW_IDLE:
        if (launch)
          next_state = NVW_BUSY;
      NVW_BUSY:
        if (done_sync)
          next_state = NVW_RELEASE;
      NVW_RELEASE:
        if (!done_sync)
          next_state = NVW_IDLE;
      default:
        next_state = NVW_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      state <= NVW_IDLE;
    else
      state <= next_state;
  end

  // mode, address and data byte latched at launch so they stay stable for the timer; page mask and data come from the live buffer
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      lat_page_mode <= 1'b0;
      lat_addr      <= '0;
      lat_byte      <= NVW_RST_BYTE;
    end
    else if (launch)
    begin
      lat_page_mode <= mode_page;
      lat_addr      <= {nv_addr_high, nv_addr_low};
      lat_byte      <= nv_data_reg;
    end
  end

  always_comb
  begin
    MEM_REQUEST             = '0;
    MEM_REQUEST.req         = (state == NVW_BUSY);
    MEM_REQUEST.page_mode   = lat_page_mode;
    MEM_REQUEST.erase_first = !lat_page_mode;
    MEM_REQUEST.addr        = lat_addr;
    MEM_REQUEST.byte_data   = lat_byte;
    MEM_REQUEST.page_mask   = page_mask;
    for (int i = 0; i < NVW_PAGE_BYTES; i++)
      MEM_REQUEST.page_data[i*8 +: 8] = page_buffer[i];
  end

  // ==========================================================================
  // interrupt enables and flags; a set wins over a same-cycle clear
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      global_irq_enable  <= 1'b0;
      nv_done_irq_enable <= 1'b0;
      mf_irq_enable      <= 1'b0;
      nv_done_irq_flag   <= 1'b0;
      mf_irq_flag        <= 1'b0;
    end
    else
    begin
      if (write_done && hit_irq)
      begin
        global_irq_enable  <= PWDATA[NVW_BIT_GIE];
        nv_done_irq_enable <= PWDATA[NVW_BIT_DONE_EN];
        mf_irq_enable      <= PWDATA[NVW_BIT_MF_EN];
        if (!PWDATA[NVW_BIT_DONE_FL])
          nv_done_irq_flag <= 1'b0;
        if (!PWDATA[NVW_BIT_MF_FL])
          mf_irq_flag <= 1'b0;
      end
      if (IRQ_SERVICED)
        mf_irq_flag <= 1'b0;
      if (cycle_end)
      begin
        nv_done_irq_flag <= 1'b1;
        mf_irq_flag      <= 1'b1;
      end
    end
  end

  // vector request; stack full holds it off
  assign IRQ_REQUEST = global_irq_enable && nv_done_irq_enable && mf_irq_enable
                       && nv_done_irq_flag && mf_irq_flag && !STACK_FULL;

endmodule

//--- bench/nvw_write_ctrl_sva.sv
// checker: port properties of the data memory write control
`timescale 1ns/1ps
module nvw_write_ctrl_sva
  import nvw_pkg::*;
#(
  parameter int ADDR_BITS = NVW_ADDR_BITS
)(
  input wire logic            CLOCK,
  input wire logic            RESET,
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PWRITE,
  input wire logic [7:0]      PADDR,
  input wire logic [31:0]     PWDATA,
  input wire logic [31:0]     PRDATA,
  input wire logic            PREADY,
  input wire logic            PSLVERR,
  input wire nvw_mem_req_type MEM_REQUEST,
  input wire logic            MEM_DONE,
  input wire logic            STACK_FULL,
  input wire logic            IRQ_SERVICED,
  input wire logic            IRQ_REQUEST
);
  // ==========
  // helpers
  logic ctl_wr;
  logic start_wr;
  logic req;
  assign ctl_wr   = PSEL && PENABLE && PWRITE && (PADDR == NVW_OFS_CONTROL);
  assign start_wr = ctl_wr && PWDATA[NVW_BIT_WRITE_ENABLE_FLAG] && PWDATA[NVW_BIT_WR];
  assign req      = MEM_REQUEST.req;

  default clocking dcb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  // ==========
  // launch and request
  a_launch_cause: assert property ($rose(req) |-> $past(start_wr))
    else $error("request rose without enable and start written");
  a_start_alone: assert property (ctl_wr && !PWDATA[NVW_BIT_WRITE_ENABLE_FLAG] && !req |=> !req)
    else $error("start without enable launched a cycle");
  a_erase_first: assert property ($rose(req) |-> MEM_REQUEST.erase_first == !$past(PWDATA[NVW_BIT_MODE]))
    else $error("erase before write does not follow mode");
  a_req_stable: assert property (req && $past(req) |-> $stable(MEM_REQUEST.addr) && $stable(MEM_REQUEST.byte_data)
    && $stable(MEM_REQUEST.page_mode) && $stable(MEM_REQUEST.page_mask))
    else $error("request contents changed during a cycle");
  // ==========
  // completion, synchronised so it can never act on the raw timer edge
  a_sync_wait: assert property ($rose(MEM_DONE) && req |-> req [*2])
    else $error("request dropped before timer completion was synchronised");
  a_done_bound: assert property ($rose(MEM_DONE) && req |-> ##[1:8] !req)
    else $error("cycle did not end after timer completion");
  a_no_relaunch: assert property ($fell(req) |-> !req [*3])
    else $error("cycle restarted without a new enable");
  // ==========
  // interrupt
  a_irq_stack: assert property (IRQ_REQUEST |-> !STACK_FULL)
    else $error("interrupt requested with stack full");
  a_irq_service: assert property (IRQ_SERVICED && !req |=> !IRQ_REQUEST)
    else $error("interrupt still requested after service");
endmodule

bind nvw_write_ctrl nvw_write_ctrl_sva #(.ADDR_BITS(ADDR_BITS)) sva_u (
  .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQUEST(MEM_REQUEST),
  .MEM_DONE(MEM_DONE), .STACK_FULL(STACK_FULL), .IRQ_SERVICED(IRQ_SERVICED), .IRQ_REQUEST(IRQ_REQUEST)
);

//--- bench/nvw_write_ctrl_test.sv
// testbench: register-level scenarios for the data memory write control
`timescale 1ns/1ps
module nvw_write_ctrl_test
  import nvw_pkg::*;
;
  logic            CLOCK = 1'b0;
  logic            RESET = 1'b1;
  logic            PSEL = 1'b0;
  logic            PENABLE = 1'b0;
  logic            PWRITE = 1'b0;
  logic [7:0]      PADDR = 8'h00;
  logic [31:0]     PWDATA = 32'h0;
  logic            MEM_DONE = 1'b0;
  logic            STACK_FULL = 1'b0;
  logic            IRQ_SERVICED = 1'b0;
  logic [31:0]     PRDATA;
  logic            PREADY;
  logic            PSLVERR;
  logic            IRQ_REQUEST;
  nvw_mem_req_type MEM_REQUEST;
  logic [31:0]     rdata;
  logic            last_err;
  int              error_cnt = 0;
  int              tests_run = 0;

  always #2.5 CLOCK = ~CLOCK;

  nvw_write_ctrl dut_u (
    .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQUEST(MEM_REQUEST),
    .MEM_DONE(MEM_DONE), .STACK_FULL(STACK_FULL), .IRQ_SERVICED(IRQ_SERVICED), .IRQ_REQUEST(IRQ_REQUEST)
  );

  // ==========
  // checks and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic guard(input logic ok);
    if (!ok)
    begin
      error_cnt++;
      results();
    end
  endtask

  // ==========
  // apb master: hold the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= addr;
    PWDATA  <= wdata;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    for (n = 0; PREADY !== 1'b1 && n < 40; n++)
      @(posedge CLOCK);
    guard(n < 40);
    rdata    = PRDATA;
    last_err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    apb(1'b1, addr, wdata);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(rdata, exp);
  endtask

  // ==========
  // memory timer side, four-phase
  task automatic wait_req(input logic lvl);
    int n;
    for (n = 0; MEM_REQUEST.req !== lvl && n < 60; n++)
      @(posedge CLOCK);
    guard(n < 60);
  endtask

  task automatic finish(input int slow);
    wait_req(1'b1);
    repeat (slow) @(posedge CLOCK);
    MEM_DONE <= 1'b1;
    wait_req(1'b0);
    MEM_DONE <= 1'b0;
    repeat (8) @(posedge CLOCK);
  endtask

  // ==========
  // scenarios
  logic [7:0] regs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};

  initial
  begin
    repeat (20) @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    for (int i = 0; i < 7; i++)
      rd(regs[i], 32'h0);
    rd(8'h1C, 32'h0);
    chkb(last_err, 1'b1);
    // control is out of reach until a pointer selects its sector
    wr(NVW_OFS_CONTROL, 32'h08);
    wr(NVW_OFS_PTR2_HIGH, 32'h01);
    rd(NVW_OFS_CONTROL, 32'h00);
    wr(NVW_OFS_CONTROL, 32'h04);
    repeat (4) @(posedge CLOCK);
    chkb(MEM_REQUEST.req, 1'b0);
    rd(NVW_OFS_CONTROL, 32'h00);
    // byte write with a slow timer
    wr(NVW_OFS_ADDR_HIGH, 32'h05);
    wr(NVW_OFS_ADDR_LOW, 32'hA3);
    wr(NVW_OFS_DATA, 32'h3C);
    wr(NVW_OFS_CONTROL, 32'h08);
    wr(NVW_OFS_CONTROL, 32'h0C);
    wait_req(1'b1);
    chk({21'h0, MEM_REQUEST.addr}, 32'h5A3);
    chk({24'h0, MEM_REQUEST.byte_data}, 32'h3C);
    chkb(MEM_REQUEST.erase_first, 1'b1);
    chkb(MEM_REQUEST.page_mode, 1'b0);
    rd(NVW_OFS_CONTROL, 32'h0C);
    finish(20);
    rd(NVW_OFS_CONTROL, 32'h00);
    rd(NVW_OFS_IRQ, 32'h30);
    // any transfer between enable and start cancels the launch
    wr(NVW_OFS_CONTROL, 32'h08);
    wr(NVW_OFS_DATA, 32'h3C);
    wr(NVW_OFS_CONTROL, 32'h0C);
    repeat (4) @(posedge CLOCK);
    chkb(MEM_REQUEST.req, 1'b0);
    rd(NVW_OFS_CONTROL, 32'h08);
    wr(NVW_OFS_CONTROL, 32'h00);
    // interrupt gating, service and software clear
    wr(NVW_OFS_IRQ, 32'h37);
    chkb(IRQ_REQUEST, 1'b1);
    STACK_FULL <= 1'b1;
    @(posedge CLOCK);
    chkb(IRQ_REQUEST, 1'b0);
    STACK_FULL   <= 1'b0;
    IRQ_SERVICED <= 1'b1;
    @(posedge CLOCK);
    IRQ_SERVICED <= 1'b0;
    @(posedge CLOCK);
    chkb(IRQ_REQUEST, 1'b0);
    rd(NVW_OFS_IRQ, 32'h17);
    wr(NVW_OFS_IRQ, 32'h07);
    rd(NVW_OFS_IRQ, 32'h07);
    // page buffer survives an enable rise, clears on its fall
    wr(NVW_OFS_CONTROL, 32'h10);
    wr(NVW_OFS_ADDR_HIGH, 32'h02);
    wr(NVW_OFS_ADDR_LOW, 32'h4C);
    wr(NVW_OFS_DATA, 32'h55);
    wr(NVW_OFS_CONTROL, 32'h18);
    chk({16'h0, MEM_REQUEST.page_mask}, 32'h1000);
    wr(NVW_OFS_CONTROL, 32'h10);
    @(posedge CLOCK);
    chk({16'h0, MEM_REQUEST.page_mask}, 32'h0);
    // page write from offset C runs into the page end; page taken as erased
    wr(NVW_OFS_ADDR_LOW, 32'h4C);
    for (int i = 1; i <= 5; i++)
      wr(NVW_OFS_DATA, (i == 5) ? 32'h99 : 32'h11 * i);
    rd(NVW_OFS_ADDR_LOW, 32'h4F);
    wr(NVW_OFS_IRQ, 32'h06);
    wr(NVW_OFS_CONTROL, 32'h18);
    wr(NVW_OFS_CONTROL, 32'h1C);
    wr(NVW_OFS_IRQ, 32'h07);
    wait_req(1'b1);
    chkb(MEM_REQUEST.page_mode, 1'b1);
    chkb(MEM_REQUEST.erase_first, 1'b0);
    chk({25'h0, MEM_REQUEST.addr[10:4]}, 32'h24);
    chk({16'h0, MEM_REQUEST.page_mask}, 32'hF000);
    chk(MEM_REQUEST.page_data[127:96], 32'h44332211);
    finish(0);
    chkb(IRQ_REQUEST, 1'b1);
    rd(NVW_OFS_CONTROL, 32'h10);
    chk({16'h0, MEM_REQUEST.page_mask}, 32'h0);
    // second reset in mid-run, with enable set and one byte tagged
    wr(NVW_OFS_ADDR_LOW, 32'h40);
    wr(NVW_OFS_DATA, 32'h77);
    wr(NVW_OFS_CONTROL, 32'h18);
    chk({16'h0, MEM_REQUEST.page_mask}, 32'h0001);
    RESET <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    rd(NVW_OFS_PTR2_HIGH, 32'h0);
    rd(NVW_OFS_IRQ, 32'h0);
    chk({16'h0, MEM_REQUEST.page_mask}, 32'h0);
    wr(NVW_OFS_PTR1_HIGH, 32'h01);
    rd(NVW_OFS_CONTROL, 32'h0);
    results();
  end
endmodule
